// [hdl/scmc_top.sv]
/*
 * system clock selection and power mode control.
 * assumes the core pulses halt and wake on this clock, the slow
 * oscillator arrives asynchronously on a pin, and the watchdog is outside.
 */
// What this block does
// - high clock from fast oscillator, low clock from slow; select picks source
// - select codes 000 to 110 give fast mode, high clock divided by 1..64
// - select code 111 gives slow mode, cpu clocked from the low clock
// - in slow mode the high clock runs only if its enable bit is set
// - six modes; cpu runs in fast and slow, stops in the four others
// - cpu-off modes entered only on halt; keep bits pick which one
// - halt with keeps 00: sleep; raw slow oscillator runs only with watchdog
// - halt with keeps 01: idle_zero_mode; low clock on, system clock only for 111
// - halt with keeps 11: idle_one_mode; high, low and system clocks all on
// - halt with keeps 10: idle_two_mode; high on, low off, system clock for 000..110
// - in fast mode high, low and raw slow clocks all run
// - enabling the fast oscillator clears stable flag, sets it once stable
// - entering cpu-off sets power-down, clears timeout flag and watchdog
// - select at bits 7..5, high keep bit 1, low keep bit 0, reset 0
`timescale 1ns/1ps
module scmc_top #(
	parameter int STABLE_CYC = scmc_pkg::HOSC_STABLE_CYC
) (
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic [7:0]               reg_addr_in,
	input  wire logic [7:0]               reg_wdata_in,
	input  wire logic                     reg_wr_in,
	input  wire logic                     reg_rd_in,
	output logic [7:0]                    reg_rdata_out,
	input  wire logic                     cpu_halt_in,
	input  wire logic                     wake_in,
	input  wire logic                     watchdog_enable_in,
	input  wire logic                     watchdog_timeout_in,
	input  wire logic                     slow_rc_osc_in,
	output scmc_pkg::scmc_clk_gate_s      clk_gate_out,
	output logic                          high_osc_enable_out,
	output logic [2:0]                    mode_out,
	output logic                          watchdog_clear_out
);

	localparam int SCNT_W = $clog2(STABLE_CYC + 1);

	// ------------------------------------------------------------------
	// register port decode
	// ------------------------------------------------------------------
	wire wr_scc   = reg_wr_in && (reg_addr_in == scmc_pkg::SCC_ADDR);
	wire wr_hosc  = reg_wr_in && (reg_addr_in == scmc_pkg::HOSC_ADDR);
	wire wr_pstat = reg_wr_in && (reg_addr_in == scmc_pkg::PSTAT_ADDR);

	scmc_pkg::scmc_ctrl_s ctrl_reg;
	scmc_pkg::scmc_ctrl_s ctrl_next;
	scmc_pkg::scmc_mode_e mode_reg;
	scmc_pkg::scmc_mode_e mode_next;
	scmc_pkg::scmc_clk_gate_s gate_next;
	logic                 hosc_en_reg;
	logic                 stable_reg;
	logic                 stable_next;
	logic [SCNT_W-1:0]    scnt_reg;
	logic [SCNT_W-1:0]    scnt_next;
	logic                 pdf_reg;
	logic                 pdf_next;
	logic                 tof_reg;
	logic                 tof_next;
	logic [7:0]           rdata_next;

	// control fields straight from the written byte
	assign ctrl_next = wr_scc ? scmc_pkg::scmc_ctrl_s'{
		sysclk_select : reg_wdata_in[scmc_pkg::SEL_MSB:scmc_pkg::SEL_LSB],
		high_keep     : reg_wdata_in[scmc_pkg::HIGH_KEEP_BIT],
		low_keep      : reg_wdata_in[scmc_pkg::LOW_KEEP_BIT]
	} : ctrl_reg;

	// ------------------------------------------------------------------
	// slow oscillator pin: three-stage synchroniser and edge
	// ------------------------------------------------------------------
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic slow_lvl_reg;
	wire  slow_lvl_next = (s2_reg == s3_reg) ? s3_reg : slow_lvl_reg;
	wire  slow_rise     = slow_lvl_next && !slow_lvl_reg;

	// first stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			s1_reg       <= 1'b0;
			s2_reg       <= 1'b0;
			s3_reg       <= 1'b0;
			slow_lvl_reg <= 1'b0;
		end else begin
			s1_reg       <= slow_rc_osc_in;
			s2_reg       <= s1_reg;
			s3_reg       <= s2_reg;
			slow_lvl_reg <= slow_lvl_next;
		end
	end

	// ------------------------------------------------------------------
	// mode selection
	// ------------------------------------------------------------------
	wire sel_slow  = (ctrl_reg.sysclk_select == scmc_pkg::SEL_SLOW);
	wire run_mode  = (mode_reg == scmc_pkg::MODE_FAST) ||
	                 (mode_reg == scmc_pkg::MODE_SLOW);
	wire halt_take = cpu_halt_in && run_mode;
	wire [1:0] keeps = {ctrl_reg.high_keep, ctrl_reg.low_keep};

	scmc_pkg::scmc_mode_e run_pick;
	scmc_pkg::scmc_mode_e halt_pick;

	assign run_pick = sel_slow ? scmc_pkg::MODE_SLOW
	                           : scmc_pkg::MODE_FAST;

	// keep bits choose the cpu-off mode; ignored while running
	always_comb begin
		case (keeps)
			2'h0:    halt_pick = scmc_pkg::MODE_SLEEP;
			2'h1:    halt_pick = scmc_pkg::MODE_IDLE_ZERO_MODE;
			2'h3:    halt_pick = scmc_pkg::MODE_IDLE_ONE_MODE;
			2'h2:    halt_pick = scmc_pkg::MODE_IDLE_TWO_MODE;
			default: halt_pick = scmc_pkg::MODE_SLEEP;
		endcase
	end

	// halt enters cpu-off, wake returns to the mode picked by select
	always_comb begin
		case (mode_reg)
			scmc_pkg::MODE_FAST,
			scmc_pkg::MODE_SLOW: begin
				mode_next = halt_take ? halt_pick : run_pick;
			end
			scmc_pkg::MODE_IDLE_ZERO_MODE,
			scmc_pkg::MODE_IDLE_ONE_MODE,
			scmc_pkg::MODE_IDLE_TWO_MODE,
			scmc_pkg::MODE_SLEEP: begin
				mode_next = wake_in ? run_pick : mode_reg;
			end
			default: mode_next = scmc_pkg::MODE_FAST;
		endcase
	end

	// ------------------------------------------------------------------
	// clock gating per mode
	// ------------------------------------------------------------------
	logic high_on;
	logic slow_on;
	logic raw_on;
	logic sys_on;

	// which clocks run in each mode
	always_comb begin
		case (mode_reg)
			scmc_pkg::MODE_FAST: begin
				high_on = 1'b1;
				slow_on = 1'b1;
				raw_on  = 1'b1;
				sys_on  = 1'b1;
			end
			scmc_pkg::MODE_SLOW: begin
				high_on = hosc_en_reg;
				slow_on = 1'b1;
				raw_on  = 1'b1;
				sys_on  = 1'b1;
			end
			scmc_pkg::MODE_IDLE_ZERO_MODE: begin
				high_on = 1'b0;
				slow_on = 1'b1;
				raw_on  = 1'b1;
				sys_on  = sel_slow;
			end
			scmc_pkg::MODE_IDLE_ONE_MODE: begin
				high_on = 1'b1;
				slow_on = 1'b1;
				raw_on  = 1'b1;
				sys_on  = 1'b1;
			end
			scmc_pkg::MODE_IDLE_TWO_MODE: begin
				high_on = 1'b1;
				slow_on = 1'b0;
				raw_on  = 1'b1;
				sys_on  = !sel_slow;
			end
			scmc_pkg::MODE_SLEEP: begin
				high_on = 1'b0;
				slow_on = 1'b0;
				raw_on  = watchdog_enable_in;
				sys_on  = 1'b0;
			end
			default: begin
				high_on = 1'b1;
				slow_on = 1'b1;
				raw_on  = 1'b1;
				sys_on  = 1'b1;
			end
		endcase
	end

	// high-speed clock divided, or the low-speed clock, as system clock
	logic div_tick;

	scmc_divider #(
		.CNT_W (6)
	) u_div (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_in),
		.run_in   (high_on),
		.sel_in   (ctrl_reg.sysclk_select),
		.tick_out (div_tick)
	);

	wire src_tick = sel_slow ? (slow_rise && slow_on)
	                         : div_tick;
	wire sys_tick = sys_on && src_tick;

	assign gate_next = '{
		cpu_tick     : run_mode && sys_tick,
		sys_tick     : sys_tick,
		high_run     : high_on,
		slow_run     : slow_on,
		raw_slow_run : raw_on
	};

	// ------------------------------------------------------------------
	// fast oscillator stable flag
	// ------------------------------------------------------------------
	wire en_rise  = wr_hosc && reg_wdata_in[scmc_pkg::HOSC_EN_BIT] &&
	                !hosc_en_reg;
	wire restart  = en_rise || !high_on;
	wire scnt_end = (scnt_reg == SCNT_W'(STABLE_CYC));

	assign scnt_next   = restart  ? '0 :
	                     scnt_end ? scnt_reg : scnt_reg + 1'b1;
	assign stable_next = !restart && scnt_end;

	// ------------------------------------------------------------------
	// power status flags: set wins over clear
	// ------------------------------------------------------------------
	wire pdf_clr = wr_pstat && reg_wdata_in[scmc_pkg::PDF_BIT];
	wire tof_clr = (wr_pstat && reg_wdata_in[scmc_pkg::TOF_BIT]) ||
	               halt_take;

	assign pdf_next = halt_take || (pdf_reg && !pdf_clr);
	assign tof_next = watchdog_timeout_in || (tof_reg && !tof_clr);

	// ------------------------------------------------------------------
	// read data, valid in the cycle after the strobe only
	// ------------------------------------------------------------------
	wire [7:0] rd_scc   = {ctrl_reg.sysclk_select, 3'h0,
	                       ctrl_reg.high_keep, ctrl_reg.low_keep};
	wire [7:0] rd_hosc  = {6'h00, stable_reg, hosc_en_reg};
	wire [7:0] rd_pstat = {3'h0, mode_reg, tof_reg, pdf_reg};

	assign rdata_next = !reg_rd_in ? 8'h00 :
	                    (reg_addr_in == scmc_pkg::SCC_ADDR)   ? rd_scc :
	                    (reg_addr_in == scmc_pkg::HOSC_ADDR)  ? rd_hosc :
	                    (reg_addr_in == scmc_pkg::PSTAT_ADDR) ? rd_pstat :
	                    8'h00;

	// ------------------------------------------------------------------
	// state registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			ctrl_reg      <= '{scmc_pkg::SEL_RST, scmc_pkg::KEEP_RST,
			                   scmc_pkg::KEEP_RST};
			hosc_en_reg   <= scmc_pkg::HOSC_EN_RST;
			mode_reg      <= scmc_pkg::MODE_FAST;
			scnt_reg      <= '0;
			stable_reg    <= scmc_pkg::FLAG_RST;
			pdf_reg       <= scmc_pkg::FLAG_RST;
			tof_reg       <= scmc_pkg::FLAG_RST;
			reg_rdata_out <= 8'h00;
		end else begin
			ctrl_reg      <= ctrl_next;
			hosc_en_reg   <= wr_hosc ? reg_wdata_in[scmc_pkg::HOSC_EN_BIT]
			                         : hosc_en_reg;
			mode_reg      <= mode_next;
			scnt_reg      <= scnt_next;
			stable_reg    <= stable_next;
			pdf_reg       <= pdf_next;
			tof_reg       <= tof_next;
			reg_rdata_out <= rdata_next;
		end
	end

	// registered gates and pulses toward the core and peripherals
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			clk_gate_out       <= '0;
			watchdog_clear_out <= 1'b0;
		end else begin
			clk_gate_out       <= gate_next;
			watchdog_clear_out <= halt_take;
		end
	end

	assign high_osc_enable_out = clk_gate_out.high_run;
	assign mode_out            = mode_reg;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence halt_with(logic [1:0] k);
		halt_take && keeps == k;
	endsequence

	sequence gated(logic h, logic s);
		!clk_gate_out.cpu_tick && clk_gate_out.high_run == h &&
		clk_gate_out.slow_run == s;
	endsequence

	a_sleep_entry : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		halt_with(2'h0) |=> mode_reg == scmc_pkg::MODE_SLEEP ##1
		gated(1'b0, 1'b0) ##0 !clk_gate_out.sys_tick)
		else $error("sleep entry gates wrong");

	a_idle_zero_mode_entry : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		halt_with(2'h1) |=> mode_reg == scmc_pkg::MODE_IDLE_ZERO_MODE ##1
		gated(1'b0, 1'b1))
		else $error("idle_zero_mode entry gates wrong");

	a_idle_one_mode_entry : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		halt_with(2'h3) |=> mode_reg == scmc_pkg::MODE_IDLE_ONE_MODE ##1
		gated(1'b1, 1'b1))
		else $error("idle_one_mode entry gates wrong");

	a_idle_two_mode_entry : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		halt_with(2'h2) |=> mode_reg == scmc_pkg::MODE_IDLE_TWO_MODE ##1
		gated(1'b1, 1'b0))
		else $error("idle_two_mode entry gates wrong");

	a_halt_sets_flags : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		halt_take && !watchdog_timeout_in
		|=> pdf_reg && !tof_reg && watchdog_clear_out)
		else $error("halt did not update power flags");

	a_fast_all_on : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		rst_n_in && mode_reg == scmc_pkg::MODE_FAST
		|=> clk_gate_out.high_run &&
		clk_gate_out.slow_run && clk_gate_out.raw_slow_run)
		else $error("a clock is off in fast mode");

	a_halt_only_runs : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		!run_mode && !wake_in |=> $stable(mode_reg))
		else $error("cpu-off mode left without wake");

	a_stable_restart : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		en_rise |=> !stable_reg ##1 !stable_reg)
		else $error("stable flag not cleared on enable");

endmodule

// [hdl/scmc_pkg.sv]
/*
 * constants, mode codes and carriers shared by the clock and mode control
 * block, its far-side model and its bench.
 * assumes a single 10 MHz clock and an 8-bit register port.
 */
package scmc_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] SCC_ADDR   = 8'h00; // system_clock_control
	localparam logic [7:0] HOSC_ADDR  = 8'h01; // fast oscillator control
	localparam logic [7:0] PSTAT_ADDR = 8'h02; // power status

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int SEL_LSB         = 5;
	localparam int SEL_MSB         = 7;
	localparam int HIGH_KEEP_BIT   = 1;
	localparam int LOW_KEEP_BIT    = 0;
	localparam int HOSC_EN_BIT     = 0;
	localparam int HOSC_STABLE_BIT = 1;
	localparam int PDF_BIT         = 0;
	localparam int TOF_BIT         = 1;
	localparam int MODE_LSB        = 2;
	localparam int MODE_MSB        = 4;

	// ------------------------------------------------------------------
	// reset values and codes
	// ------------------------------------------------------------------
	localparam logic [2:0] SEL_RST     = 3'h0;
	localparam logic       KEEP_RST    = 1'b0;
	localparam logic       HOSC_EN_RST = 1'b1;
	localparam logic       FLAG_RST    = 1'b0;
	localparam logic [2:0] SEL_SLOW    = 3'h7;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int HOSC_STABLE_NS  = 16000;
	localparam int HOSC_STABLE_CYC =
		(HOSC_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_FAST  = 3'h0,
		MODE_SLOW  = 3'h1,
		MODE_IDLE_ONE_MODE = 3'h3,
		MODE_IDLE_ZERO_MODE = 3'h2,
		MODE_IDLE_TWO_MODE = 3'h6,
		MODE_SLEEP = 3'h7
	} scmc_mode_e;

	typedef struct packed {
		logic cpu_tick;     // cpu clock enable
		logic sys_tick;     // system clock enable for peripherals
		logic high_run;     // high_speed_clock running
		logic slow_run;     // peripheral low-speed clock running
		logic raw_slow_run; // raw_slow_osc_clock running
	} scmc_clk_gate_s;

	typedef struct packed {
		logic [2:0] sysclk_select;
		logic       high_keep;
		logic       low_keep;
	} scmc_ctrl_s;

endpackage

// [hdl/scmc_divider.sv]
/*
 * divider of the high-speed clock: one tick every 1..64 cycles.
 * assumes run_in low whenever the high-speed clock is stopped.
 */
`timescale 1ns/1ps
module scmc_divider #(
	parameter int CNT_W = 6
) (
	input  wire logic       clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       run_in,
	input  wire logic [2:0] sel_in,
	output logic            tick_out
);

	// ------------------------------------------------------------------
	// ratio decode and counter
	// ------------------------------------------------------------------
	function automatic logic [CNT_W-1:0] ratio_mask(input logic [2:0] s);
		logic [CNT_W-1:0] one;
		one = {{(CNT_W-1){1'b0}}, 1'b1};
		ratio_mask = (one << s) - one;
	endfunction

	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             tick_next;
	wire  [CNT_W-1:0] mask_w = ratio_mask(sel_in); // codes 0..6 -> /1../64

	assign cnt_next  = run_in ? cnt_reg + 1'b1 : cnt_reg;
	assign tick_next = run_in && ((cnt_reg & mask_w) == mask_w);

	// counter holds while the high-speed clock is stopped
	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			cnt_reg  <= '0;
			tick_out <= 1'b0;
		end else begin
			cnt_reg  <= cnt_next;
			tick_out <= tick_next;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	a_div_full_rate : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		(rst_n_in && run_in && sel_in == 3'h0) |=> tick_out)
		else $error("divide by one lost a tick");

	a_div_by_two : assert property (@(posedge clk_in)
		disable iff (!rst_n_in)
		(tick_out && run_in && sel_in == 3'h1 && $stable(sel_in))
		|=> !tick_out)
		else $error("divide by two ticked twice in a row");

endmodule

// [tb/scmc_far_model.sv]
/*
 * far side of the clock and mode control block: the free-running slow
 * oscillator and the consumers that count cpu and system clock enables.
 * assumes the bench clears the counters before each counting window.
 */
`timescale 1ns/1ps
module scmc_far_model (
	input  wire logic                     clk_in,
	input  wire logic                     count_clr_in,
	input  wire scmc_pkg::scmc_clk_gate_s gate_in,
	output logic                          slow_osc_out,
	output logic [7:0]                    cpu_cnt_out,
	output logic [7:0]                    sys_cnt_out
);
	// ------------------------------------------------------------------
	// slow oscillator
	// ------------------------------------------------------------------
	// free running, period not a multiple of clk_in, so phase drifts
	initial begin
		slow_osc_out = 1'b0;
		forever #765 slow_osc_out = ~slow_osc_out;
	end

	// ------------------------------------------------------------------
	// clock consumers
	// ------------------------------------------------------------------
	// count enables seen by the core and by the peripherals
	always_ff @(posedge clk_in) begin
		if (count_clr_in) begin
			cpu_cnt_out <= 8'h00;
			sys_cnt_out <= 8'h00;
		end else begin
			cpu_cnt_out <= cpu_cnt_out + 8'(gate_in.cpu_tick);
			sys_cnt_out <= sys_cnt_out + 8'(gate_in.sys_tick);
		end
	end
endmodule

// [tb/scmc_tb_top.sv]
/*
 * self-checking bench of the clock and mode control block.
 * assumes the design files and the far-side model are compiled first.
 */
`timescale 1ns/1ps
module scmc_tb_top;
	localparam int STAB = 8;
	logic                     clk_in, rst_n_in, wr, rd, halt, wake;
	logic                     wd_en, wd_to, cnt_clr, slow_osc, hosc_en;
	logic                     wd_clr;
	logic [7:0]               addr, wdata, rdata, cpu_cnt, sys_cnt, d;
	logic [2:0]               mode;
	scmc_pkg::scmc_clk_gate_s gate;
	int                       mismatches, checks, cycles;

	scmc_top #(.STABLE_CYC(STAB)) dut_u (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .cpu_halt_in(halt), .wake_in(wake),
		.watchdog_enable_in(wd_en), .watchdog_timeout_in(wd_to),
		.slow_rc_osc_in(slow_osc), .clk_gate_out(gate),
		.high_osc_enable_out(hosc_en), .mode_out(mode),
		.watchdog_clear_out(wd_clr));

	scmc_far_model far_u (
		.clk_in(clk_in), .count_clr_in(cnt_clr), .gate_in(gate),
		.slow_osc_out(slow_osc), .cpu_cnt_out(cpu_cnt),
		.sys_cnt_out(sys_cnt));

	// ------------------------------------------------------------------
	// clock, watchdog on hangs
	// ------------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------------
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
			input string what);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s got %h want %h", $time, what,
				seen, exp);
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk_in);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge clk_in);
		wr    <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a);
		@(posedge clk_in);
		rd   <= 1'b1;
		addr <= a;
		@(posedge clk_in);
		rd   <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic count(input int n);
		@(posedge clk_in);
		cnt_clr <= 1'b1;
		@(posedge clk_in);
		cnt_clr <= 1'b0;
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic pulse_halt();
		@(posedge clk_in);
		halt <= 1'b1;
		@(posedge clk_in);
		halt <= 1'b0;
		#1;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	// reset values, register layout, unmapped place
	task automatic t_regs();
		chk(8'({gate.high_run, gate.slow_run, gate.raw_slow_run}), 8'h07,
			"fast gates");
		rreg(8'h00); chk(d, 8'h00, "control reset");
		rreg(8'h02); chk(d, 8'h00, "status reset");
		wreg(8'h00, 8'hff); rreg(8'h00);
		chk(d, 8'he3, "control");
		@(posedge clk_in); #1; chk(rdata, 8'h00, "read data drops");
		chk(8'(mode), 8'(scmc_pkg::MODE_SLOW), "slow mode");
		wreg(8'h00, 8'h00); wreg(8'h10, 8'hff);
		rreg(8'h10); chk(d, 8'h00, "unmapped");
		rreg(8'h00); chk(d, 8'h00, "control clear");
		chk(8'(mode), 8'(scmc_pkg::MODE_FAST), "fast mode");
		$display("test regs done");
	endtask

	// every divide ratio of fast mode
	task automatic t_divide();
		for (int s = 0; s < 7; s++) begin
			wreg(8'h00, {3'(s), 5'h00});
			repeat (70) @(posedge clk_in);
			count(128);
			chk(sys_cnt, 8'(128 >> s), "sys ticks");
			chk(cpu_cnt, 8'(128 >> s), "cpu ticks");
		end
		wreg(8'h00, 8'h00);
		$display("test divide done");
	endtask

	// stable flag on re-enable, slow mode with fast oscillator off
	task automatic t_osc();
		wreg(8'h01, 8'h00); wreg(8'h01, 8'h01);
		rreg(8'h01); chk(d, 8'h01, "not yet stable");
		repeat (STAB + 4) @(posedge clk_in);
		rreg(8'h01); chk(d, 8'h03, "stable");
		wreg(8'h00, 8'he0); count(60);
		chk(8'(cpu_cnt != 0), 8'h01, "cpu runs slow");
		chk(8'(gate.high_run), 8'h01, "high kept");
		wreg(8'h01, 8'h00); repeat (3) @(posedge clk_in); #1;
		chk(8'({gate.high_run, hosc_en}), 8'h00, "high stopped");
		wreg(8'h01, 8'h01); wreg(8'h00, 8'h00);
		repeat (STAB + 4) @(posedge clk_in);
		$display("test osc done");
	endtask

	// halt with every keep pair, both clock sources, then wake
	task automatic t_halt();
		logic [2:0] mtab [4];
		logic [1:0] k;
		logic       s7, xsys;
		mtab = '{scmc_pkg::MODE_SLEEP, scmc_pkg::MODE_IDLE_ZERO_MODE,
			scmc_pkg::MODE_IDLE_TWO_MODE, scmc_pkg::MODE_IDLE_ONE_MODE};
		for (int i = 0; i < 8; i++) begin
			k  = 2'(i);
			s7 = (i > 3);
			xsys = (k == 2'h3) || (k == 2'h1 && s7) || (k == 2'h2 && !s7);
			wd_en <= s7;
			wreg(8'h00, {{3{s7}}, 3'h0, k});
			repeat (20) @(posedge clk_in);
			@(posedge clk_in); wd_to <= 1'b1;
			@(posedge clk_in); wd_to <= 1'b0;
			rreg(8'h02); chk(d & 8'h02, 8'h02, "timeout set");
			pulse_halt();
			chk(8'(wd_clr), 8'h01, "watchdog clear");
			chk(8'(mode), 8'(mtab[k]), "cpu-off mode");
			repeat (4) @(posedge clk_in);
			pulse_halt();
			chk(8'(wd_clr), 8'h00, "halt refused");
			count(40);
			chk(8'(mode), 8'(mtab[k]), "second halt ignored");
			chk(cpu_cnt, 8'h00, "cpu stopped");
			chk(8'(sys_cnt != 0), 8'(xsys),
				"system clock");
			chk(8'({gate.high_run, gate.slow_run}), 8'(k),
				"high and low");
			chk(8'(gate.raw_slow_run), 8'((k != 2'h0) || s7),
				"raw slow");
			rreg(8'h02);
			chk(d, {3'h0, mtab[k], 2'h1}, "status flags");
			@(posedge clk_in); wake <= 1'b1;
			@(posedge clk_in); wake <= 1'b0;
			repeat (3) @(posedge clk_in); #1;
			chk(8'(mode), s7 ? 8'(scmc_pkg::MODE_SLOW) :
				8'(scmc_pkg::MODE_FAST), "woken");
			wreg(8'h02, 8'h03); rreg(8'h02);
			chk(d, {3'h0, s7 ? scmc_pkg::MODE_SLOW : scmc_pkg::MODE_FAST,
				2'h0}, "flags cleared");
		end
		$display("test halt done");
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		{rst_n_in, wr, rd, halt, wake, wd_en, wd_to, cnt_clr} = 8'h00;
		addr = 8'h00;
		wdata = 8'h00;
		mismatches = 0;
		checks = 0;
		cycles = 0;
		repeat (6) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		#1;
		t_regs();
		t_divide();
		t_osc();
		t_halt();
		wrap_up();
	end
endmodule
